// ===== logic/obp_pkg.sv
// Constants for the byte programming sequencer: register map, field
// positions, timing counts and the sequencer states.
// Assumes a 100 MHz system clock.
package obp_pkg;
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STAT   = 8'h04;
    localparam logic [7:0] OFS_ISTAT  = 8'h08;
    localparam logic [7:0] OFS_IMASK  = 8'h0C;
    localparam logic [7:0] OFS_ID     = 8'h10;
    localparam int CTRL_PROG = 0;
    localparam int CTRL_ID   = 1;
    localparam int EV_DONE   = 0;
    localparam int EV_FAIL   = 1;
    localparam int EV_ID     = 2;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    localparam int CLK_NS    = 10;
    localparam int T_SET_NS  = 2000;
    localparam int SET_CYC   = (T_SET_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_DV_NS   = 1000;
    localparam int DV_CYC    = (T_DV_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_US  = 100;
    localparam int PULSE_CYC_DEF = PULSE_US * 1000 / CLK_NS;
    localparam logic [3:0] RETRY_MAX = 4'hA;
    typedef enum logic [8:0] {
        S_IDLE   = 9'h001,
        S_PWRUP  = 9'h002,
        S_SETUP  = 9'h004,
        S_PULSE  = 9'h008,
        S_HOLD   = 9'h010,
        S_VERIFY = 9'h020,
        S_PWRDN  = 9'h040,
        S_READ   = 9'h080,
        S_IDRD   = 9'h100
    } obp_state_e;
endpackage : obp_pkg

// ===== logic/obp_prog_ctrl.sv
// Programmer for a 64K x 8 one-time-programmable memory: drives its pins,
// runs the pulse, verify/retry and read-back phases, reads the id codes.
// Assumes IMG_DATA shows the source byte for ADDR, and external supply
// switches follow VCC_ON, VCC_HI, VPP_HI and ID_HV.
`timescale 1ns/1ns
module obp_prog_ctrl
    import obp_pkg::*;
#(
    parameter int ADDR_W    = 16,
    parameter int PULSE_CYC = PULSE_CYC_DEF
) (
    input  wire logic              CLK_SYS,
    input  wire logic              RST,
    input  wire logic [7:0]        S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output      logic              S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output      logic              S_AXI_WREADY,
    output      logic [1:0]        S_AXI_BRESP,
    output      logic              S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    input  wire logic [7:0]        S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output      logic              S_AXI_ARREADY,
    output      logic [31:0]       S_AXI_RDATA,
    output      logic [1:0]        S_AXI_RRESP,
    output      logic              S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    output      logic [ADDR_W-1:0] ADDR,
    output      logic              CE_N,
    output      logic              OE_N,
    output      logic              VPP_HI,
    output      logic              VCC_ON,
    output      logic              VCC_HI,
    output      logic              ID_HV,
    output      logic [7:0]        DQ_O,
    output      logic              DQ_OE,
    input  wire logic [7:0]        DQ_I,
    input  wire logic [7:0]        IMG_DATA,
    output      logic              IRQ
);
    typedef struct packed {
        obp_state_e        st;
        logic              stp;
        logic [15:0]       tmr;
        logic [ADDR_W-1:0] addr;
        logic [3:0]        retry;
        logic              pass2;
        logic              fail;
        logic              done;
        logic              ce_n;
        logic              oe_n;
        logic              vpp_hi;
        logic              vcc_on;
        logic              vcc_hi;
        logic              id_hv;
        logic [7:0]        dq_o;
        logic              dq_oe;
        logic [7:0]        mfr;
        logic [7:0]        dev;
        logic              id_ok;
        logic [2:0]        istat;
        logic [2:0]        imask;
        logic              irq;
        logic              aw_rdy;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              ar_rdy;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
    } obp_regs_s;

    function automatic logic [15:0] ld(input int n);
        ld = 16'(n - 1);
    endfunction : ld

    obp_regs_s r_r;
    obp_regs_s r_nxt;
    logic       last;
    logic       match;
    logic       tmr_z;
    logic       wr_go;
    logic       rd_go;
    logic       start_prog;
    logic       start_id;
    logic [2:0] ev;
    logic [2:0] clr;

    assign last  = r_r.addr == {ADDR_W{1'b1}};
    assign match = DQ_I == IMG_DATA;
    assign tmr_z = r_r.tmr == 16'h0000;
    assign wr_go = r_r.aw_rdy && S_AXI_AWVALID && S_AXI_WVALID;
    assign rd_go = r_r.ar_rdy && S_AXI_ARVALID;
    assign start_prog = wr_go && S_AXI_AWADDR == OFS_CTRL
                        && S_AXI_WSTRB[0] && S_AXI_WDATA[CTRL_PROG];
    assign start_id   = wr_go && S_AXI_AWADDR == OFS_CTRL
                        && S_AXI_WSTRB[0] && S_AXI_WDATA[CTRL_ID];

    always_comb begin
        r_nxt = r_r;
        ev = 3'h0;
        clr = 3'h0;
        if (!tmr_z) begin
            r_nxt.tmr = r_r.tmr - 16'h0001;
        end
        unique case (r_r.st)
            S_IDLE: begin
                // A program order wins if both bits are written at once
                if (start_prog) begin
                    r_nxt.st = S_PWRUP;
                    r_nxt.stp = 1'b0;
                    r_nxt.addr = '0;
                    r_nxt.vcc_on = 1'b1;
                    r_nxt.vcc_hi = 1'b1;
                    r_nxt.pass2 = 1'b0;
                    r_nxt.retry = 4'h0;
                    r_nxt.fail = 1'b0;
                    r_nxt.done = 1'b0;
                    r_nxt.tmr = ld(SET_CYC);
                end else if (start_id) begin
                    r_nxt.st = S_IDRD;
                    r_nxt.addr = '0;
                    r_nxt.vcc_on = 1'b1;
                    r_nxt.id_hv = 1'b1;
                    r_nxt.ce_n = 1'b0;
                    r_nxt.oe_n = 1'b0;
                    r_nxt.id_ok = 1'b0;
                    r_nxt.tmr = ld(SET_CYC);
                end
            end
            S_PWRUP: begin
                if (tmr_z && !r_r.stp) begin
                    r_nxt.vpp_hi = 1'b1;
                    r_nxt.stp = 1'b1;
                    r_nxt.tmr = ld(SET_CYC);
                end else if (tmr_z) begin
                    r_nxt.st = S_SETUP;
                    r_nxt.tmr = ld(SET_CYC);
                end
            end
            S_SETUP: begin
                r_nxt.dq_o = IMG_DATA;
                r_nxt.dq_oe = 1'b1;
                if (tmr_z) begin
                    r_nxt.st = S_PULSE;
                    r_nxt.ce_n = 1'b0;
                    r_nxt.tmr = ld(PULSE_CYC);
                end
            end
            S_PULSE: begin
                if (tmr_z) begin
                    r_nxt.st = S_HOLD;
                    r_nxt.ce_n = 1'b1;
                    r_nxt.tmr = ld(SET_CYC);
                end
            end
            S_HOLD: begin
                if (tmr_z) begin
                    r_nxt.dq_oe = 1'b0;
                    r_nxt.stp = 1'b0;
                    r_nxt.tmr = ld(SET_CYC);
                    if (r_r.pass2) begin
                        r_nxt.st = S_VERIFY;
                        r_nxt.vpp_hi = 1'b0;
                    end else if (last) begin
                        r_nxt.st = S_VERIFY;
                        r_nxt.vpp_hi = 1'b0;
                        r_nxt.pass2 = 1'b1;
                        r_nxt.addr = '0;
                    end else begin
                        r_nxt.st = S_SETUP;
                        r_nxt.addr = r_r.addr + 1'b1;
                    end
                end
            end
            S_VERIFY: begin
                if (tmr_z && !r_r.stp) begin
                    r_nxt.stp = 1'b1;
                    r_nxt.ce_n = 1'b0;
                    r_nxt.oe_n = 1'b0;
                    r_nxt.tmr = ld(DV_CYC);
                end else if (tmr_z) begin
                    r_nxt.ce_n = 1'b1;
                    r_nxt.oe_n = 1'b1;
                    r_nxt.tmr = ld(SET_CYC);
                    if (match && last) begin
                        r_nxt.st = S_PWRDN;
                        r_nxt.retry = 4'h0;
                    end else if (match) begin
                        // Next byte is verified first, pulsed only on miss
                        r_nxt.st = S_VERIFY;
                        r_nxt.stp = 1'b0;
                        r_nxt.addr = r_r.addr + 1'b1;
                        r_nxt.retry = 4'h0;
                    end else if (r_r.retry == RETRY_MAX) begin
                        r_nxt.st = S_PWRDN;
                        r_nxt.fail = 1'b1;
                    end else begin
                        r_nxt.st = S_SETUP;
                        r_nxt.retry = r_r.retry + 4'h1;
                        r_nxt.vpp_hi = 1'b1;
                    end
                end
            end
            S_PWRDN: begin
                // Programming pin is already low here, so core drops last
                if (tmr_z) begin
                    r_nxt.vcc_hi = 1'b0;
                    if (r_r.fail) begin
                        r_nxt.st = S_IDLE;
                        r_nxt.vcc_on = 1'b0;
                        r_nxt.done = 1'b1;
                        ev[EV_DONE] = 1'b1;
                        ev[EV_FAIL] = 1'b1;
                    end else begin
                        r_nxt.st = S_READ;
                        r_nxt.addr = '0;
                        r_nxt.ce_n = 1'b0;
                        r_nxt.oe_n = 1'b0;
                        r_nxt.tmr = ld(SET_CYC);
                    end
                end
            end
            S_READ: begin
                if (tmr_z) begin
                    r_nxt.tmr = ld(DV_CYC);
                    r_nxt.addr = r_r.addr + 1'b1;
                    if (!match) begin
                        r_nxt.fail = 1'b1;
                    end
                    if (last) begin
                        r_nxt.st = S_IDLE;
                        r_nxt.ce_n = 1'b1;
                        r_nxt.oe_n = 1'b1;
                        r_nxt.vcc_on = 1'b0;
                        r_nxt.done = 1'b1;
                        ev[EV_DONE] = 1'b1;
                        ev[EV_FAIL] = r_r.fail || !match;
                    end
                end
            end
            S_IDRD: begin
                if (tmr_z && !r_r.addr[0]) begin
                    r_nxt.mfr = DQ_I;
                    r_nxt.addr = {{(ADDR_W-1){1'b0}}, 1'b1};
                    r_nxt.tmr = ld(DV_CYC);
                end else if (tmr_z) begin
                    r_nxt.dev = DQ_I;
                    r_nxt.st = S_IDLE;
                    r_nxt.id_hv = 1'b0;
                    r_nxt.ce_n = 1'b1;
                    r_nxt.oe_n = 1'b1;
                    r_nxt.vcc_on = 1'b0;
                    r_nxt.id_ok = 1'b1;
                    ev[EV_ID] = 1'b1;
                end
            end
        endcase
        // Write channel: ready only once both halves wait, so no skid
        if (wr_go) begin
            r_nxt.aw_rdy = 1'b0;
            r_nxt.bvalid = 1'b1;
            r_nxt.bresp = RESP_OK;
            unique case (S_AXI_AWADDR)
                OFS_CTRL, OFS_STAT, OFS_ID: ;
                OFS_ISTAT: clr = S_AXI_WSTRB[0] ? S_AXI_WDATA[2:0] : 3'h0;
                OFS_IMASK: begin
                    if (S_AXI_WSTRB[0]) begin
                        r_nxt.imask = S_AXI_WDATA[2:0];
                    end
                end
                default: r_nxt.bresp = RESP_ERR;
            endcase
        end else if (!r_r.aw_rdy && !r_r.bvalid && S_AXI_AWVALID
                     && S_AXI_WVALID) begin
            r_nxt.aw_rdy = 1'b1;
        end
        if (r_r.bvalid && S_AXI_BREADY) begin
            r_nxt.bvalid = 1'b0;
        end
        if (rd_go) begin
            r_nxt.ar_rdy = 1'b0;
            r_nxt.rvalid = 1'b1;
            r_nxt.rresp = RESP_OK;
            r_nxt.rdata = 32'h0000_0000;
            unique case (S_AXI_ARADDR)
                OFS_CTRL: ;
                OFS_STAT: r_nxt.rdata = {(16)'(r_r.addr), 8'h00, r_r.retry,
                    r_r.id_ok, r_r.fail, r_r.done, r_r.st != S_IDLE};
                OFS_ISTAT: r_nxt.rdata[2:0] = r_r.istat;
                OFS_IMASK: r_nxt.rdata[2:0] = r_r.imask;
                OFS_ID: r_nxt.rdata[15:0] = {r_r.dev, r_r.mfr};
                default: r_nxt.rresp = RESP_ERR;
            endcase
        end else if (!r_r.ar_rdy && !r_r.rvalid && S_AXI_ARVALID) begin
            r_nxt.ar_rdy = 1'b1;
        end
        if (r_r.rvalid && S_AXI_RREADY) begin
            r_nxt.rvalid = 1'b0;
        end
        // A new event beats a clear written in the same cycle
        r_nxt.istat = (r_r.istat & ~clr) | ev;
        r_nxt.irq = |(r_nxt.istat & r_nxt.imask);
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            r_r <= '{st: S_IDLE, ce_n: 1'b1, oe_n: 1'b1, default: '0};
        end else begin
            r_r <= r_nxt;
        end
    end

    assign S_AXI_AWREADY = r_r.aw_rdy;
    assign S_AXI_WREADY  = r_r.aw_rdy;
    assign S_AXI_BVALID  = r_r.bvalid;
    assign S_AXI_BRESP   = r_r.bresp;
    assign S_AXI_ARREADY = r_r.ar_rdy;
    assign S_AXI_RVALID  = r_r.rvalid;
    assign S_AXI_RRESP   = r_r.rresp;
    assign S_AXI_RDATA   = r_r.rdata;
    assign ADDR   = r_r.addr;
    assign CE_N   = r_r.ce_n;
    assign OE_N   = r_r.oe_n;
    assign VPP_HI = r_r.vpp_hi;
    assign VCC_ON = r_r.vcc_on;
    assign VCC_HI = r_r.vcc_hi;
    assign ID_HV  = r_r.id_hv;
    assign DQ_O   = r_r.dq_o;
    assign DQ_OE  = r_r.dq_oe;
    assign IRQ    = r_r.irq;

    // Strobe-low length while the programming pin is high
    logic [15:0] pw_cnt;
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            pw_cnt <= 16'h0000;
        end else begin
            pw_cnt <= (!CE_N && VPP_HI) ? pw_cnt + 16'h0001 : 16'h0000;
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    a_pulse_width: assert property ($rose(CE_N) && $past(VPP_HI)
        |-> pw_cnt == 16'(PULSE_CYC)) else $error("pulse width wrong");
    a_first_addr: assert property (r_r.st == S_PWRUP
        |-> ADDR == '0) else $error("start address not zero");
    a_prog_supply: assert property (!CE_N && VPP_HI
        |-> VCC_HI && VCC_ON) else $error("pulse without raised supply");
    a_supply_order: assert property (VPP_HI
        |-> VCC_HI && VCC_ON) else $error("core supply after prog pin");
    a_first_pass: assert property (!r_r.pass2 && r_r.st == S_HOLD
        && tmr_z && !last |=> r_r.st == S_SETUP && ADDR == $past(ADDR) + 1'b1)
        else $error("first pass verified or skipped");
    a_retry_cap: assert property (r_r.retry <= RETRY_MAX)
        else $error("retry count above limit");
    a_fail_stop: assert property (r_r.st == S_VERIFY && r_r.stp
        && tmr_z && !match && r_r.retry == RETRY_MAX
        |=> r_r.st == S_PWRDN && r_r.fail) else $error("no stop on fail");
    a_next_addr: assert property (r_r.st == S_VERIFY && r_r.stp
        && tmr_z && match && !last |=> ADDR == $past(ADDR) + 1'b1
        && r_r.retry == 4'h0) else $error("no advance after verify");
    a_read_supply: assert property (r_r.st == S_READ
        |-> !VPP_HI && !VCC_HI) else $error("read not at normal supply");
    a_read_fail: assert property (r_r.st == S_READ && tmr_z
        && !match |=> r_r.fail) else $error("read mismatch not flagged");
    a_id_volt: assert property (r_r.st == S_IDRD |-> ID_HV)
        else $error("id read without raised line");
    a_done_flag: assert property ($rose(r_r.done)
        |-> r_r.st == S_IDLE && r_r.istat[EV_DONE])
        else $error("done without event");

    c_prog_pass: cover property ($rose(r_r.done) && !r_r.fail);
    c_prog_fail: cover property ($rose(r_r.done) && r_r.fail);
    c_retry: cover property (r_r.retry == 4'h2);
    c_id_read: cover property ($rose(r_r.id_ok));
endmodule : obp_prog_ctrl

// ===== sim/obp_mem_model.sv
// Behavioural 2**AW x 8 (8 x 8 by default) one-time memory on the programmer's pins.
// Assumes CE_N, OE_N and supplies are levels sampled on clk.
`timescale 1ns/1ns
module obp_mem_model #(
    parameter int         AW    = 3,
    parameter int         PW    = 20,
    parameter logic [7:0] MAKER = 8'h5A, // Arbitrary value
    parameter logic [7:0] DTYPE = 8'hC3  // Arbitrary value
) (
    input  wire logic          clk,
    input  wire logic [AW-1:0] addr,
    input  wire logic          ce_n,
    input  wire logic          oe_n,
    input  wire logic          vpp_hi,
    input  wire logic          vcc_on,
    input  wire logic          vcc_hi,
    input  wire logic          id_hv,
    input  wire logic [7:0]    dq_o,
    input  wire logic          dq_oe,
    output      logic [7:0]    dq_i
);
    logic [7:0]    mem [2**AW];
    int            pcnt [2**AW];
    int            viol;
    int            width;
    int            need_n;
    logic [AW-1:0] need_a;
    logic          flip;
    logic          ce_q;
    logic          vpp_q;
    // A new blank part: every byte erased, one address may be stubborn
    task automatic load(input logic [AW-1:0] a, input int n, input logic f);
        foreach (mem[i]) begin
            mem[i] = 8'hFF;
            pcnt[i] = 0;
        end
        need_a = a;
        need_n = n;
        flip = f;
    endtask : load
    initial begin
        viol = 0;
        width = 0;
        ce_q = 1'b1;
        vpp_q = 1'b0;
        dq_i = 8'h00;
        load('0, 1, 1'b0);
    end
    always @(posedge clk) begin
        ce_q <= ce_n;
        vpp_q <= vpp_hi;
        width <= ce_n ? 0 : width + 1;
        if (vpp_hi && !vcc_on) viol = viol + 1;
        // A verify read may end as the programming pin rises again
        if (ce_n && !ce_q && vpp_q) begin
            if (width < PW * 95 / 100 || width > PW * 105 / 100) viol++;
            if (!vcc_hi || !dq_oe) viol = viol + 1;
            pcnt[addr] <= pcnt[addr] + 1;
            if (pcnt[addr] + 1 >= (addr == need_a ? need_n : 1))
                mem[addr] <= mem[addr] & dq_o;
        end
        if (!ce_n && !oe_n && !vpp_hi && vcc_on)
            dq_i <= id_hv ? (addr[0] ? DTYPE : MAKER)
                  : mem[addr] ^ {7'h0, flip & !vcc_hi};
        else
            dq_i <= ~dq_i; // Released bus must not look like held data
    end
endmodule : obp_mem_model

// ===== sim/test_otp_byte_program_sequencer.sv
// Self-checking bench for the programmer: AXI4-Lite master, memory model.
// Assumes the model file and the design package are compiled first.
`timescale 1ns/1ns
module test_otp_byte_program_sequencer;
    import obp_pkg::*;
    localparam int         AW    = 3;
    localparam int         PW    = 20;
    localparam int         LIM   = 40000;
    localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
    localparam logic [7:0] DTYPE = 8'hC3; // Arbitrary value
    typedef struct {logic [1:0] r; logic [31:0] d; logic [31:0] m;} obp_exp_s;
    logic [7:0]    awaddr, araddr, dq_o, dq_i, img_data;
    logic          clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic          awready, wready, bvalid, arready, rvalid, irq;
    logic [31:0]   wdata, rdata, seed;
    logic [1:0]    bresp, rresp;
    logic [AW-1:0] addr;
    logic          ce_n, oe_n, vpp_hi, vcc_on, vcc_hi, id_hv, dq_oe;
    logic [7:0]    img [2**AW];
    obp_exp_s      q [$];
    obp_exp_s      e;
    int            n_errors, check_count;
    assign img_data = img[addr];
    obp_prog_ctrl #(.ADDR_W(AW), .PULSE_CYC(PW)) i_dut (
        .CLK_SYS(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .ADDR(addr), .CE_N(ce_n), .OE_N(oe_n),
        .VPP_HI(vpp_hi), .VCC_ON(vcc_on), .VCC_HI(vcc_hi), .ID_HV(id_hv),
        .DQ_O(dq_o), .DQ_OE(dq_oe), .DQ_I(dq_i), .IMG_DATA(img_data),
        .IRQ(irq));
    obp_mem_model #(.AW(AW), .PW(PW), .MAKER(MAKER), .DTYPE(DTYPE)) i_mem (
        .clk(clk), .addr(addr), .ce_n(ce_n), .oe_n(oe_n), .vpp_hi(vpp_hi),
        .vcc_on(vcc_on), .vcc_hi(vcc_hi), .id_hv(id_hv), .dq_o(dq_o),
        .dq_oe(dq_oe), .dq_i(dq_i));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk
    task automatic close_out;
        $display("Errors %0d, checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    // Ready is looked at on the falling edge, so the next rising edge
    // is the transfer edge whatever order the processes run in
    task automatic wt(input int s);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((s == 0 ? awready & wready : s == 1 ? bvalid :
                    s == 2 ? arready : s == 3 ? rvalid : irq) !== 1'b1
                   && n < LIM);
        if (n >= LIM) chk(1'b0, "wait ran out");
    endtask : wt
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] r);
        q.push_back('{r, 32'h0, 32'h0});
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        wt(0);
        @(posedge clk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        wt(1);
        @(posedge clk);
        bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic [1:0] r);
        q.push_back('{r, d, m});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        wt(2);
        @(posedge clk);
        arvalid <= 1'b0;
        wt(3);
        @(posedge clk);
        rready <= 1'b0;
    endtask : axr
    task automatic run(input logic [31:0] c, input logic [AW-1:0] sa,
                       input int sn, input logic f);
        foreach (img[i]) begin
            seed = xs(seed);
            // Never the erased value, so an unprogrammed byte misses
            img[i] <= seed[7:0] & 8'h7F;
        end
        i_mem.load(sa, sn, f);
        axw(OFS_CTRL, c, RESP_OK);
        wt(4);
    endtask : run
    task automatic irq_is(input logic v);
        repeat (3) @(posedge clk);
        chk(irq === v, "interrupt level");
    endtask : irq_is
    always @(posedge clk) begin
        if ((rvalid & rready) === 1'b1 || (bvalid & bready) === 1'b1) begin
            if (q.size() == 0) begin
                chk(1'b0, "answer with nothing expected");
            end else begin
                e = q.pop_front();
                if (rvalid === 1'b1)
                    chk(rresp === e.r && ((rdata ^ e.d) & e.m) === 32'h0,
                        "read data or response");
                else
                    chk(bresp === e.r, "write response");
            end
        end
    end
    initial begin
        #600000;
        n_errors++;
        close_out();
    end
    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata} = 48'h0;
        seed = 32'h2F1CE9CA;
        n_errors = 0;
        check_count = 0;
        foreach (img[i]) img[i] = 8'h00;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        axr(OFS_ISTAT, 32'h0, 32'h7, RESP_OK);
        axr(OFS_STAT, 32'h0, 32'hF, RESP_OK);
        axr(8'h14, 32'h0, 32'hFFFFFFFF, RESP_ERR);
        axw(8'h18, 32'h1, RESP_ERR);
        axw(OFS_IMASK, 32'h3, RESP_OK);
        axr(OFS_IMASK, 32'h3, 32'h7, RESP_OK);
        run(32'h1, 2, 4, 1'b0);
        axr(OFS_STAT, 32'h2, 32'h7, RESP_OK);
        axr(OFS_ISTAT, 32'h1, 32'h7, RESP_OK);
        foreach (img[i]) chk(i_mem.mem[i] === img[i], "image");
        chk(i_mem.pcnt[0] === 1 && i_mem.pcnt[2] === 4, "pulses");
        chk({vcc_on, vpp_hi, ce_n} === 3'b001, "supplies off");
        axw(OFS_ISTAT, 32'h1, RESP_OK);
        irq_is(1'b0);
        run(32'h1, 5, 99, 1'b0);
        axr(OFS_STAT, 32'h6, 32'h7, RESP_OK);
        axr(OFS_ISTAT, 32'h3, 32'h7, RESP_OK);
        chk(i_mem.pcnt[5] === 11, "ten retry pulses");
        chk(i_mem.pcnt[6] === 1, "stopped on failure");
        axw(OFS_ISTAT, 32'h3, RESP_OK);
        axw(OFS_IMASK, 32'h2, RESP_OK);
        run(32'h1, 0, 1, 1'b1);
        axr(OFS_STAT, 32'h6, 32'h7, RESP_OK);
        axw(OFS_ISTAT, 32'h3, RESP_OK);
        axw(OFS_IMASK, 32'h4, RESP_OK);
        run(32'h2, 0, 1, 1'b0);
        axr(OFS_ID, {16'h0, DTYPE, MAKER}, 32'hFFFF, RESP_OK);
        axr(OFS_STAT, 32'h8, 32'h9, RESP_OK);
        chk(id_hv === 1'b0 && i_mem.viol === 0, "device limits");
        axw(OFS_IMASK, 32'h0, RESP_OK);
        irq_is(1'b0);
        axw(OFS_IMASK, 32'h4, RESP_OK);
        irq_is(1'b1);
        axw(OFS_ISTAT, 32'h4, RESP_OK);
        irq_is(1'b0);
        chk(q.size() == 0, "answers outstanding");
        close_out();
    end
endmodule : test_otp_byte_program_sequencer
